// *** key_scan_data_handshake_test.sv ***
`default_nettype none
module key_scan_data_handshake_test
	import kss_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SCAN = 40;
	localparam int RESCAN = 80;
	localparam int LIMIT = 20000;
	logic mclk, reset, sleep_ack, key_scan_enable, link_clk, ce, di;
	logic do_out, do_oe_n, key_pending, do_wire;
	logic [KEY_BITS-1:0] key_in, k;
	kss_word_type rd;
	int fails = 0, cmp_count = 0, cycles = 0;

	// board pull-up on the open-drain line
	assign do_wire = do_oe_n ? 1'b1 : do_out;

	kss_key_scan #(.SCAN_CYCLES(SCAN), .RESCAN_CYCLES(RESCAN)) DUT (.mclk(mclk),
		.reset(reset), .key_in(key_in), .sleep_ack(sleep_ack),
		.key_scan_enable(key_scan_enable), .link_clk(link_clk), .ce(ce), .di(di),
		.do_out(do_out), .do_oe_n(do_oe_n), .key_pending(key_pending));
	kss_host_model host (.link_clk(link_clk), .ce(ce), .di(di), .do_wire(do_wire));

	// system clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	// hang guard
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails++;
			finish_test();
		end
	end

	task automatic cmp_bit(input string what, input logic exp, input logic got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %b seen %b", what, exp, got);
		end
	endtask

	task automatic cmp_word(input string what, input kss_word_type exp, input kss_word_type got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic kss_word_type exp_word(input logic [KEY_BITS-1:0] kk, input logic s);
		return '{sleep_ack_bit: s, key_state_bits: kk};
	endfunction

	// sync, state change and output register add a few cycles
	function automatic logic in_window(input int n, input int base);
		return (n >= base + 2) && (n <= base + 7);
	endfunction

	// second value lands after mid-scan so the passes disagree
	task automatic key_event(input logic [KEY_BITS-1:0] k1, input logic [KEY_BITS-1:0] k2,
		input logic s);
		int n;
		logic late;
		late = (k1 != k2);
		@(negedge mclk);
		key_in = k1;
		sleep_ack = s;
		n = 0;
		if (late) begin
			repeat (SCAN / 2 + 4) @(negedge mclk);
			key_in = k2;
			n = SCAN / 2 + 4;
		end
		while (key_pending !== 1'b1 && n < 400) begin
			@(negedge mclk);
			n++;
		end
		cmp_bit("scan time", 1'b1, in_window(n, late ? RESCAN : SCAN));
		repeat (4) @(negedge mclk);
		cmp_bit("pending line", 1'b0, do_wire);
		if (late) begin
			host.read_word(8'h42, rd);
			cmp_bit("pending kept", 1'b1, key_pending);
		end
		host.read_word(KEY_READ_ADDR, rd);
		cmp_word("key word", exp_word(k2, s), rd);
		repeat (10) @(negedge mclk);
		cmp_bit("pending after read", 1'b0, key_pending);
		cmp_bit("line after read", 1'b1, do_wire);
		repeat (RESCAN + 10) @(negedge mclk);
		$display("test key event done");
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		reset = 1'b1;
		key_in = '0;
		sleep_ack = 1'b0;
		key_scan_enable = 1'b0;
		void'($urandom(32'ha300));
		repeat (3) host.pulse();
		repeat (5) @(negedge mclk);
		cmp_bit("line in reset", 1'b1, do_wire);
		cmp_bit("pending in reset", 1'b0, key_pending);
		reset = 1'b0;
		// link side sees reset low before the first frame, else two address bits are lost
		repeat (2) host.pulse();
		@(negedge mclk);
		key_in = '1;
		repeat (RESCAN + 20) @(negedge mclk);
		cmp_bit("pending disabled", 1'b0, key_pending);
		host.read_word(KEY_READ_ADDR, rd);
		cmp_word("disabled read", '1, rd);
		$display("test disabled done");
		key_in = '0;
		// let the key synchroniser drain first, or a stale all-ones word starts a scan
		repeat (3) @(negedge mclk);
		key_scan_enable = 1'b1;
		key_event('1, '1, 1'b1);
		key_event(30'h0000_0001, 30'h2000_0000, 1'b0);
		for (int i = 0; i < 4; i++) begin
			k = 30'($urandom);
			key_event(k, i[0] ? ~k : k, 1'($urandom));
		end
		key_event('0, '0, 1'b0);
		// read started while the line is high
		host.read_word(KEY_READ_ADDR, rd);
		repeat (10) @(negedge mclk);
		cmp_bit("pending idle read", 1'b0, key_pending);
		cmp_bit("line idle read", 1'b1, do_wire);
		$display("test idle read done");
		finish_test();
	end
endmodule
`default_nettype wire

// *** kss_host_model.sv ***
`default_nettype none
module kss_host_model
	import kss_pkg::*;
(
	// serial bus towards the device
	output logic link_clk,
	output logic ce,
	output logic di,
	// open-drain data line after the pull-up
	input  wire logic do_wire
);
	timeunit 1ns;
	timeprecision 100ps;

	// bus idles with ce low so the pending line is visible
	initial begin
		link_clk = 1'b0;
		ce = 1'b0;
		di = 1'b0;
	end

	// one link clock, which stands low between frames
	task automatic pulse();
		#62.5 link_clk = 1'b1;
		#62.5 link_clk = 1'b0;
	endtask

	// address with ce low, then 32 clocks with ce high
	task automatic read_word(input logic [7:0] addr, output kss_word_type w);
		logic [READ_BITS-1:0] bits;
		for (int i = 0; i < ADDR_BITS; i++) begin
			di = addr[i];
			pulse();
		end
		ce = 1'b1;
		for (int k = 0; k < 32; k++) begin
			di = ~di; // don't care while reading, so keep it moving
			#62.5 link_clk = 1'b1;
			// a bit shown at edge k-1 is taken at edge k
			if (k > 0) bits[k-1] = do_wire;
			#62.5 link_clk = 1'b0;
		end
		ce = 1'b0;
		w = kss_word_type'(bits);
	endtask
endmodule
`default_nettype wire

// *** kss_key_scan.sv ***
`default_nettype none
module kss_key_scan
	import kss_pkg::*;
#(
	parameter int SCAN_CYCLES   = SCAN_CYCLES_DEF,
	parameter int RESCAN_CYCLES = RESCAN_CYCLES_DEF
) (
	// system
	input  wire logic                mclk,
	input  wire logic                reset,
	// key matrix pins and device state
	input  wire logic [KEY_BITS-1:0] key_in,
	input  wire logic                sleep_ack,
	input  wire logic                key_scan_enable,
	// serial link
	input  wire logic                link_clk,
	input  wire logic                ce,
	input  wire logic                di,
	output logic                     do_out,
	output logic                     do_oe_n,
	// status
	output logic                     key_pending
);

	kss_scan_type        state_r, state_nxt;
	logic [CNT_W-1:0]    cnt_r, cnt_nxt;
	logic [KEY_BITS-1:0] snap_r, snap_nxt;
	kss_word_type        data_r, data_nxt;
	logic                oe_n_r, oe_n_nxt;
	logic                pend_r, pend_nxt;
	logic                out_r;
	logic [KEY_BITS-1:0] key_s1_r, key_s2_r;
	logic                ce_s1_r, ce_s2_r;
	logic                rd_s1_r, rd_s2_r;
	logic                bit_s1_r, bit_s2_r;
	logic                tog_s1_r, tog_s2_r, tog_seen_r;
	logic                done_ev;
	logic                link_bit, link_rd, link_tog;

	// link-clock side: address capture and bit streaming
	kss_link u_link (
		.link_clk (link_clk),
		.reset    (reset),
		.ce       (ce),
		.di       (di),
		.word     (data_r),
		.read_bit (link_bit),
		.reading  (link_rd),
		.done_tog (link_tog)
	);

	// two-stage synchronisers; the first stage feeds only the second
	// key lines are synced bit by bit: a skewed sample is caught by the second pass
	always_ff @(posedge mclk) begin
		key_s1_r <= key_in;
		key_s2_r <= key_s1_r;
		ce_s1_r  <= ce;
		ce_s2_r  <= ce_s1_r;
		rd_s1_r  <= link_rd;
		rd_s2_r  <= rd_s1_r;
		bit_s1_r <= link_bit;
		bit_s2_r <= bit_s1_r;
		tog_s1_r <= link_tog;
		tog_s2_r <= tog_s1_r;
	end

	assign done_ev = tog_s2_r ^ tog_seen_r;

	// scan sequencer, pending handshake and pin drive
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		snap_nxt  = snap_r;
		data_nxt  = data_r;
		case (state_r)
			S_IDLE: begin
				cnt_nxt = '0;
				// a press or a release both differ from the last report
				if (key_s2_r != data_r.key_state_bits)
					state_nxt = S_PASS1;
			end
			S_PASS1: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == CNT_W'(SCAN_CYCLES / 2 - 1))
					snap_nxt = key_s2_r;
				if (cnt_r == CNT_W'(SCAN_CYCLES - 1)) begin
					if (key_s2_r == snap_r) begin
						state_nxt = S_PEND;
						data_nxt  = '{sleep_ack_bit: sleep_ack, key_state_bits: key_s2_r};
					end else begin
						state_nxt = S_PASS2;
					end
				end
			end
			S_PASS2: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == CNT_W'(RESCAN_CYCLES - 1)) begin
					state_nxt = S_PEND;
					data_nxt  = '{sleep_ack_bit: sleep_ack, key_state_bits: key_s2_r};
				end
			end
			S_PEND: begin
				// only a finished read, or scanning switched off, lets the next scan start
				if (done_ev)
					state_nxt = S_IDLE;
			end
			default: begin
				state_nxt = S_IDLE;
			end
		endcase
		// scanning off: drop back, keep last data unless a pass ends in that same cycle
		if (!key_scan_enable)
			state_nxt = S_IDLE;
		pend_nxt = (state_nxt == S_PEND);
		// open drain: oe_n low pulls the pin low
		if (!key_scan_enable)
			oe_n_nxt = 1'b1;
		else if (rd_s2_r)
			oe_n_nxt = bit_s2_r;
		else
			oe_n_nxt = ~((state_r == S_PEND) & ~ce_s2_r);
	end

	// scanner registers
	always_ff @(posedge mclk) begin
		if (reset) begin
			state_r    <= S_IDLE;
			cnt_r      <= '0;
			snap_r     <= KEY_DATA_RST;
			data_r     <= WORD_RST;
			oe_n_r     <= 1'b1;
			pend_r     <= 1'b0;
			out_r      <= 1'b0;
			tog_seen_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			cnt_r      <= cnt_nxt;
			snap_r     <= snap_nxt;
			data_r     <= data_nxt;
			oe_n_r     <= oe_n_nxt;
			pend_r     <= pend_nxt;
			out_r      <= 1'b0;
			tog_seen_r <= tog_s2_r;
		end
	end

	assign do_out      = out_r;
	assign do_oe_n     = oe_n_r;
	assign key_pending = pend_r;

	// cycles since the scan left idle, checked independently of cnt_r
	logic [CNT_W-1:0] age_r;
	always_ff @(posedge mclk) begin
		if (reset || state_r == S_IDLE || state_r == S_PEND)
			age_r <= '0;
		else
			age_r <= age_r + 1'b1;
	end

	a_agree_scan_time: assert property (@(posedge mclk) disable iff (reset)
		($past(state_r) == S_PASS1 && state_r == S_PEND) |-> $past(age_r) == CNT_W'(SCAN_CYCLES - 1))
		else $error("agreeing scan did not finish at its scan time");

	a_rescan_time: assert property (@(posedge mclk) disable iff (reset)
		($past(state_r) == S_PASS2 && state_r == S_PEND) |-> $past(age_r) == CNT_W'(RESCAN_CYCLES - 1))
		else $error("repeated scan did not finish at its rescan time");

	a_pend_pulls_low: assert property (@(posedge mclk) disable iff (reset)
		(state_r == S_PEND && !ce_s2_r && !rd_s2_r && key_scan_enable) |=> !do_oe_n)
		else $error("pending key not shown low while ce low");

	a_idle_stays_high: assert property (@(posedge mclk) disable iff (reset)
		(state_r != S_PEND && !rd_s2_r) |=> do_oe_n)
		else $error("data output pulled low with nothing pending");

	a_reset_clears: assert property (@(posedge mclk) disable iff (reset)
		$fell(reset) |-> (data_r.key_state_bits == KEY_DATA_RST && state_r == S_IDLE && do_oe_n))
		else $error("key data or state not cleared by reset");

	a_disabled_idle: assert property (@(posedge mclk) disable iff (reset)
		!key_scan_enable |=> state_r == S_IDLE && !key_pending)
		else $error("scanner active while scanning is disabled");

	a_disabled_high: assert property (@(posedge mclk) disable iff (reset)
		!key_scan_enable |=> do_oe_n ##1 (do_oe_n || $past(key_scan_enable)))
		else $error("data output low while scanning is disabled");

	a_pend_until_read: assert property (@(posedge mclk) disable iff (reset)
		(state_r == S_PEND && !done_ev && key_scan_enable) |=> state_r == S_PEND && key_pending)
		else $error("pending dropped without a completed read");

	a_release_on_read: assert property (@(posedge mclk) disable iff (reset)
		(state_r == S_PEND && done_ev) |=> (state_r == S_IDLE && !key_pending) ##1 do_oe_n || rd_s2_r)
		else $error("pending not released after a completed read");

	// a new key state seen while idle starts the first pass at once
	a_scan_starts: assert property (@(posedge mclk) disable iff (reset)
		(state_r == S_IDLE && key_scan_enable && key_s2_r != data_r.key_state_bits)
		|=> state_r == S_PASS1)
		else $error("changed keys did not start a scan");

	a_word_held: assert property (@(posedge mclk) disable iff (reset)
		state_r == S_PEND |=> $stable(data_r))
		else $error("key word changed while waiting to be read");

	// readout bits reach the pin one register after the synchroniser
	a_read_follows: assert property (@(posedge mclk) disable iff (reset)
		(rd_s2_r && key_scan_enable) |=> do_oe_n == $past(bit_s2_r))
		else $error("data output does not follow the readout bit");

endmodule
`default_nettype wire

// *** kss_link.sv ***
`default_nettype none
module kss_link
	import kss_pkg::*;
(
	// link clock and mclk-domain reset
	input  wire logic         link_clk,
	input  wire logic         reset,
	// serial bus
	input  wire logic         ce,
	input  wire logic         di,
	// key word, held steady by the scanner while pending
	input  wire kss_word_type word,
	// towards the scanner domain
	output logic              read_bit,
	output logic              reading,
	output logic              done_tog
);

	logic                 rst_s1_r, rst_s2_r;
	logic [ADDR_BITS-1:0] addr_r, addr_nxt;
	logic [ACNT_W-1:0]    acnt_r, acnt_nxt;
	logic [IDX_W-1:0]     idx_r, idx_nxt;
	logic                 bit_r, bit_nxt;
	logic                 rd_r, rd_nxt;
	logic                 tog_r, tog_nxt;
	logic [READ_BITS-1:0] word_v;

	assign word_v = word;

	// reset brought over to the link clock; needs two edges after reset falls, before the first frame
	always_ff @(posedge link_clk) begin
		rst_s1_r <= reset;
		rst_s2_r <= rst_s1_r;
	end

	// address shift while ce low, bit streaming once ce rises after 43h
	always_comb begin
		addr_nxt = addr_r;
		acnt_nxt = acnt_r;
		idx_nxt  = idx_r;
		bit_nxt  = bit_r;
		rd_nxt   = rd_r;
		tog_nxt  = tog_r;
		if (!ce) begin
			addr_nxt = {di, addr_r[ADDR_BITS-1:1]};
			if (acnt_r != ACNT_W'(ADDR_BITS))
				acnt_nxt = acnt_r + 1'b1;
			rd_nxt  = 1'b0;
			idx_nxt = '0;
			bit_nxt = 1'b1;
		end else if (rd_r) begin
			if (idx_r == IDX_W'(READ_BITS)) begin
				rd_nxt   = 1'b0;
				tog_nxt  = ~tog_r; // read completed, tell the scanner
				acnt_nxt = '0;
				bit_nxt  = 1'b1;
			end else begin
				bit_nxt = word_v[idx_r];
				idx_nxt = idx_r + 1'b1;
			end
		end else if (acnt_r == ACNT_W'(ADDR_BITS) && addr_r == KEY_READ_ADDR) begin
			rd_nxt  = 1'b1;
			bit_nxt = word_v[0];
			idx_nxt = IDX_W'(1);
		end else begin
			acnt_nxt = '0; // other addresses are not ours
		end
	end

	// link registers
	always_ff @(posedge link_clk) begin
		if (rst_s2_r) begin
			addr_r <= '0;
			acnt_r <= '0;
			idx_r  <= '0;
			bit_r  <= 1'b1;
			rd_r   <= 1'b0;
			tog_r  <= 1'b0;
		end else begin
			addr_r <= addr_nxt;
			acnt_r <= acnt_nxt;
			idx_r  <= idx_nxt;
			bit_r  <= bit_nxt;
			rd_r   <= rd_nxt;
			tog_r  <= tog_nxt;
		end
	end

	assign read_bit = bit_r;
	assign reading  = rd_r;
	assign done_tog = tog_r;

endmodule
`default_nettype wire

// *** kss_pkg.sv ***
`default_nettype none
package kss_pkg;

	// key matrix and read frame shape
	localparam int KEY_BITS = 30;
	localparam int READ_BITS = 31;
	localparam int ADDR_BITS = 8;
	localparam logic [7:0] KEY_READ_ADDR = 8'h43;

	// scan times in oscillator periods, mclk cycles per oscillator period
	localparam int SCAN_OSC_PERIODS = 4800;
	localparam int RESCAN_OSC_PERIODS = 9600;
	localparam int MCLK_PER_OSC = 1;
	localparam int SCAN_CYCLES_DEF = SCAN_OSC_PERIODS * MCLK_PER_OSC;
	localparam int RESCAN_CYCLES_DEF = RESCAN_OSC_PERIODS * MCLK_PER_OSC;
	localparam int CNT_W = 14;

	// link side counter widths
	localparam int ACNT_W = 4;
	localparam int IDX_W = 5;

	// reset values
	localparam logic [KEY_BITS-1:0] KEY_DATA_RST = 30'h0000_0000;

	// key data word as read out: key bits first, sleep ack last
	typedef struct packed {
		logic                sleep_ack_bit;
		logic [KEY_BITS-1:0] key_state_bits;
	} kss_word_type;

	localparam kss_word_type WORD_RST = '{sleep_ack_bit: 1'b0, key_state_bits: KEY_DATA_RST};

	// scanner states, one-hot
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0001,
		S_PASS1 = 4'b0010,
		S_PASS2 = 4'b0100,
		S_PEND  = 4'b1000
	} kss_scan_type;

endpackage
`default_nettype wire
